// *** pkg/core_mem_pkg.sv ***
package core_mem_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACCESS_TIME_NS = 600;
  localparam int CYCLE_TIME_NS = 1000;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
  localparam logic [CNT_W-1:0] CYCLE_CNT = CNT_W'(CYCLE_CYC);
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // Register codes
  // ****************************************
  localparam logic [3:0] EXT_CODE_MIN = 4'h6;
  localparam logic [3:0] REG_BASE_DEF = 4'h6;
  localparam logic [3:0] REG_COUNT = 4'h4;
  localparam logic [1:0] OFS_LOW = 2'h0;
  localparam logic [1:0] OFS_HIGH = 2'h1;
  localparam logic [1:0] OFS_DATA = 2'h2;
  localparam logic [1:0] OFS_CTL = 2'h3;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_START = 0;
  localparam int CTL_READ = 1;
  localparam int CTL_AUTO_DATA = 2;
  localparam int CTL_AUTO_HIGH = 3;
  localparam int CTL_AUTO_LOW = 4;
  localparam int CTL_SPLIT = 5;
  localparam int CTL_CLEAR = 6;
  localparam int CTL_BUSY = 7;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int ADDR_W = 14;
  localparam int HIGH_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_MASK_4K = 14'h0FFF;
  localparam logic [ADDR_W-1:0] ADDR_MASK_16K = 14'h3FFF;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [HIGH_W-1:0] HIGH_RST = 6'h00;
  localparam logic [8:0] DATA_RST = 9'h000;
  localparam logic [6:0] CTL_RST = 7'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0] code;
    logic [7:0] xsel;
    logic [7:0] ysel;
    logic [7:0] result;
    logic dest;
    logic strobe;
  } proc_bus_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [8:0] wdata;
    logic write;
  } array_req_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ACCESS,
    S_RESTORE
  } cyc_state_t;

endpackage

// *** design/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // pin_sync

// *** design/core_mem_regs.sv ***
`timescale 1ns/1ns
// Behaviour
// - Four registers: written from result bus as destination, read onto read bus.
// - Addressed register is driven onto read bus while its code stays present.
// - Addressed register captures result bus on write strobe when flag high.
// - Low address register holds the low eight address bits.
// - High address register holds six high bits, fourteen-bit address in total.
// - Address registers are two ranks; second rank loads at cycle start.
// - Data register byte plus parity; second rank loads at start, supplies write.
// - Read data loads first data rank 600 ns after cycle start.
// - A cycle lasts 1 us before the next, a split-mode read 600 ns; parity is a build option.
// - Control takes start (not kept, reads 0) and holds read select, split mode and clear bits.
// - Three enables auto-start a cycle on data, high or low address writes.
// - Control writes ignored during a cycle; reads always allowed.
// - Optionally decode X and Y buses as extra register-select bits.
// - Memory capacity configurable from 4K to 16K bytes.
// - Interface answers only codes 0110 through 1111.
module core_mem_regs
  import core_mem_pkg::*;
#(
  parameter logic [3:0] reg_base = REG_BASE_DEF,
  parameter bit ext_sel_en = 1'b0,
  parameter logic [15:0] ext_sel_match = 16'h0000,
  parameter logic [ADDR_W-1:0] addr_mask = ADDR_MASK_16K,
  parameter bit parity_en = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  // Processor register bus
  input wire logic [3:0] reg_addr_bus,
  input wire logic [7:0] x_sel_bus,
  input wire logic [7:0] y_sel_bus,
  input wire logic [7:0] result_write_bus,
  input wire logic destination_flag_line,
  input wire logic write_strobe_phase,
  output logic [8:0] register_read_bus,
  output logic register_read_en,
  // Core array electronics
  output array_req_t array_req,
  output logic array_go,
  input wire logic [8:0] array_rdata,
  // Status
  output logic cycle_busy
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  proc_bus_t pins_raw;
  proc_bus_t pins_s;
  logic [$bits(proc_bus_t)-1:0] pins_q;

  assign pins_raw.code = reg_addr_bus;
  assign pins_raw.xsel = x_sel_bus;
  assign pins_raw.ysel = y_sel_bus;
  assign pins_raw.result = result_write_bus;
  assign pins_raw.dest = destination_flag_line;
  assign pins_raw.strobe = write_strobe_phase;

  pin_sync #(
    .WIDTH($bits(proc_bus_t))
  ) u_pin_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .d(pins_raw),
    .q(pins_q)
  );

  assign pins_s = pins_q;

  // ****************************************
  // Decode
  // ****************************************
  logic strobe_q;
  logic strobe_rise;
  logic ext_ok;
  logic [3:0] code_ofs;
  logic [1:0] sel;
  logic hit;
  logic wr;
  logic wr_low;
  logic wr_high;
  logic wr_data;
  logic wr_ctl;

  function automatic logic odd_par(input logic [7:0] b);
    odd_par = parity_en ? ~(^b) : 1'b0;
  endfunction

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q <= 1'b0;
    end else if (ce) begin
      strobe_q <= pins_s.strobe;
    end
  end

  assign strobe_rise = pins_s.strobe & ~strobe_q;
  assign ext_ok = !ext_sel_en || ({pins_s.xsel, pins_s.ysel} == ext_sel_match);
  assign code_ofs = pins_s.code - reg_base;
  assign sel = code_ofs[1:0];
  assign hit = ext_ok && (pins_s.code >= EXT_CODE_MIN) && (pins_s.code >= reg_base)
               && (code_ofs < REG_COUNT);
  assign wr = strobe_rise && pins_s.dest && hit;

  // Control writes dropped while a cycle runs
  always_comb begin
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_data = 1'b0;
    wr_ctl = 1'b0;
    if (wr) begin
      if (sel == OFS_LOW) begin
        wr_low = 1'b1;
      end else if (sel == OFS_HIGH) begin
        wr_high = 1'b1;
      end else if (sel == OFS_DATA) begin
        wr_data = 1'b1;
      end else if ((sel == OFS_CTL) && !cycle_busy) begin
        wr_ctl = 1'b1;
      end
    end
  end

  // ****************************************
  // First-rank registers
  // ****************************************
  logic [7:0] low_q;
  logic [HIGH_W-1:0] high_q;
  logic [8:0] data_q;
  logic [6:0] ctl_q;
  logic [7:0] res;
  logic start;
  logic load_read;
  logic [6:0] ctl_eff;
  cyc_state_t state_q;
  logic [CNT_W-1:0] cnt_q;

  assign res = pins_s.result;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= LOW_RST;
    end else if (ce && wr_low) begin
      low_q <= res;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      high_q <= HIGH_RST;
    end else if (ce && wr_high) begin
      high_q <= res[HIGH_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= DATA_RST;
    end else if (ce) begin
      if (load_read) begin
        data_q <= array_rdata;
      end else if (start && ctl_eff[CTL_CLEAR]) begin
        data_q <= DATA_RST;
      end else if (wr_data) begin
        data_q <= {res, odd_par(res)};
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= CTL_RST;
    end else if (ce && wr_ctl) begin
      ctl_q <= {res[6:1], 1'b0};
    end
  end

  // ****************************************
  // Cycle start
  // ****************************************
  logic start_req;

  assign ctl_eff = wr_ctl ? res[6:0] : ctl_q;
  assign start_req = (wr_ctl && res[CTL_START])
                     || (wr_data && ctl_q[CTL_AUTO_DATA])
                     || (wr_high && ctl_q[CTL_AUTO_HIGH])
                     || (wr_low && ctl_q[CTL_AUTO_LOW]);
  assign start = start_req && (state_q == S_IDLE);

  // ****************************************
  // Second rank
  // ****************************************
  logic [ADDR_W-1:0] next_addr;

  assign next_addr = {(wr_high ? res[HIGH_W-1:0] : high_q), (wr_low ? res : low_q)};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      array_req <= '0;
    end else if (ce && start) begin
      array_req.addr <= next_addr & addr_mask;
      array_req.write <= ~ctl_eff[CTL_READ];
      if (ctl_eff[CTL_CLEAR]) begin
        array_req.wdata <= DATA_RST;
      end else begin
        array_req.wdata <= wr_data ? {res, odd_par(res)} : data_q;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      array_go <= 1'b0;
    end else if (ce) begin
      array_go <= start;
    end
  end

  // ****************************************
  // Cycle timing
  // ****************************************
  assign load_read = (state_q == S_ACCESS) && (cnt_q == ACCESS_CNT - 7'h01) && !array_req.write;
  assign cycle_busy = (state_q != S_IDLE);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      case (state_q)
        S_IDLE: begin
          cnt_q <= '0;
          if (start) begin
            state_q <= S_ACCESS;
          end
        end
        S_ACCESS: begin
          cnt_q <= cnt_q + 7'h01;
          if (cnt_q == ACCESS_CNT - 7'h01) begin
            if (!array_req.write && ctl_q[CTL_SPLIT]) begin
              state_q <= S_IDLE;
            end else begin
              state_q <= S_RESTORE;
            end
          end
        end
        S_RESTORE: begin
          cnt_q <= cnt_q + 7'h01;
          if (cnt_q == CYCLE_CNT - 7'h01) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Read bus
  // ****************************************
  logic [7:0] rd_byte;
  logic [8:0] rd_word;

  always_comb begin
    rd_byte = 8'h00;
    if (sel == OFS_LOW) begin
      rd_byte = low_q;
    end else if (sel == OFS_HIGH) begin
      rd_byte = {2'h0, high_q};
    end else if (sel == OFS_DATA) begin
      rd_byte = data_q[8:1];
    end else begin
      rd_byte = {cycle_busy, ctl_q[6:1], 1'b0};
    end
  end

  // Data register keeps its stored parity
  always_comb begin
    rd_word = {rd_byte, odd_par(rd_byte)};
    if (sel == OFS_DATA) begin
      rd_word = data_q;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      register_read_bus <= 9'h000;
      register_read_en <= 1'b0;
    end else if (ce) begin
      register_read_en <= hit;
      register_read_bus <= hit ? rd_word : 9'h000;
    end
  end

endmodule // core_mem_regs

// *** sim/core_mem_regs_sva.sv ***
`timescale 1ns/1ns
module core_mem_regs_sva
  import core_mem_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register bus
  input wire logic [3:0] reg_addr_bus,
  input wire logic [8:0] register_read_bus,
  input wire logic register_read_en,
  // Array side
  input wire array_req_t array_req,
  input wire logic array_go,
  input wire logic cycle_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [6:0] busy_q;
  logic [6:0] gap_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) busy_q <= 7'h00;
    else busy_q <= cycle_busy ? busy_q + 7'h01 : 7'h00;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) gap_q <= 7'h7F;
    else gap_q <= array_go ? 7'h01 : (gap_q == 7'h7F ? gap_q : gap_q + 7'h01);
  end
  // Go pulse rises with busy and lasts one cycle
  sequence s_go;
    array_go ##1 !array_go;
  endsequence
  a_start_go: assert property ($rose(cycle_busy) |-> s_go) else $error("no go pulse");
  a_go_busy: assert property (array_go |-> cycle_busy) else $error("go while idle");
  a_go_gap: assert property (array_go |-> gap_q >= 7'h3C) else $error("starts too close");
  a_busy_len: assert property ($fell(cycle_busy) |-> busy_q inside {[7'h3A:7'h3D], [7'h62:7'h65]})
    else $error("bad cycle length");
  a_req_hold: assert property ($changed(array_req) |-> array_go) else $error("request moved");
  a_read_en: assert property (register_read_en == ($past(reg_addr_bus, 3) inside {[4'h6:4'h9]}))
    else $error("bad read enable");
  a_idle_zero: assert property (!register_read_en |-> register_read_bus == 9'h000) else $error("bus not 0");
  a_odd_par: assert property (register_read_en && $past(reg_addr_bus, 3) != 4'h8 |-> ^register_read_bus)
    else $error("even parity");
endmodule // core_mem_regs_sva

bind core_mem_regs core_mem_regs_sva chk (.mclk, .arst_n, .reg_addr_bus, .register_read_bus,
  .register_read_en, .array_req, .array_go, .cycle_busy);

// *** sim/proc_model.sv ***
`timescale 1ns/1ns
module proc_model (
  // Clock
  input wire logic mclk,
  // Register bus
  output logic [3:0] reg_addr_bus,
  output logic [7:0] result_write_bus,
  output logic destination_flag_line,
  output logic write_strobe_phase,
  input wire logic [8:0] register_read_bus
);
  initial begin
    reg_addr_bus = 4'h0;
    result_write_bus = 8'h00;
    destination_flag_line = 1'b0;
    write_strobe_phase = 1'b0;
  end
  task automatic wr(input logic [3:0] c, input logic [7:0] d, input logic f);
    @(posedge mclk);
    reg_addr_bus <= c;
    result_write_bus <= d;
    destination_flag_line <= f;
    repeat (8) @(posedge mclk);
    write_strobe_phase <= 1'b1;
    repeat (8) @(posedge mclk);
    write_strobe_phase <= 1'b0;
    repeat (8) @(posedge mclk);
    reg_addr_bus <= 4'h0;
    result_write_bus <= ~d;
    destination_flag_line <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] c, output logic [8:0] q);
    @(posedge mclk);
    reg_addr_bus <= c;
    repeat (6) @(posedge mclk);
    q = register_read_bus;
    reg_addr_bus <= 4'h0;
  endtask
endmodule // proc_model

// *** sim/core_memory_register_interface_test.sv ***
`timescale 1ns/1ns
module core_memory_register_interface_test;
  import core_mem_pkg::*;
  logic mclk;
  logic arst_n;
  logic [3:0] reg_addr_bus;
  logic [7:0] result_write_bus;
  logic destination_flag_line;
  logic write_strobe_phase;
  logic [8:0] register_read_bus;
  logic register_read_en;
  array_req_t array_req;
  logic array_go;
  logic [8:0] array_rdata;
  logic cycle_busy;
  logic [8:0] q;
  int fails;
  int cmp_count;
  int ticks;
  int dur;
  core_mem_regs dut (.mclk, .arst_n, .ce(1'b1), .reg_addr_bus, .x_sel_bus(8'h00), .y_sel_bus(8'h00),
    .result_write_bus, .destination_flag_line, .write_strobe_phase, .register_read_bus,
    .register_read_en, .array_req, .array_go, .array_rdata, .cycle_busy);
  proc_model proc (.mclk, .reg_addr_bus, .result_write_bus, .destination_flag_line,
    .write_strobe_phase, .register_read_bus);
  // Array answers an address-derived byte
  assign array_rdata = {array_req.addr[7:0] ^ 8'hA5, ~^(array_req.addr[7:0] ^ 8'hA5)};
  function automatic logic [8:0] pb(input logic [7:0] b);
    return {b, ~^b};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] c, input logic [8:0] e);
    proc.rd(c, q);
    chk({15'h0000, q}, {15'h0000, e});
  endtask
  task automatic wait_idle;
    dur = 0;
    while (cycle_busy !== 1'b0 && dur < 200) begin
      @(posedge mclk);
      dur++;
    end
    chk({23'h000000, cycle_busy}, 24'h000000);
  endtask
  task automatic t_regs;
    proc.wr(4'h6, 8'h3C, 1'b1);
    proc.wr(4'h7, 8'hFF, 1'b1);
    proc.wr(4'h6, 8'hC3, 1'b0);
    rdchk(4'h6, pb(8'h3C));
    rdchk(4'h7, pb(8'h3F));
    rdchk(4'hA, 9'h000);
    rdchk(4'h5, 9'h000);
  endtask
  task automatic t_read;
    proc.wr(4'h9, 8'h03, 1'b1);
    chk({9'h000, array_req.addr, array_req.write}, {9'h000, 14'h3F3C, 1'b0});
    proc.wr(4'h9, 8'h00, 1'b1);
    rdchk(4'h9, pb(8'h82));
    wait_idle();
    rdchk(4'h9, pb(8'h02));
    rdchk(4'h8, pb(8'h99));
  endtask
  task automatic t_auto;
    logic [7:0] en [3] = '{8'h04, 8'h08, 8'h10};
    logic [3:0] cd [3] = '{4'h8, 4'h7, 4'h6};
    logic [13:0] ad [3] = '{14'h3F3C, 14'h1A3C, 14'h1A5A};
    for (int i = 0; i < 3; i++) begin
      proc.wr(4'h9, en[i], 1'b1);
      proc.wr(cd[i], 8'h5A, 1'b1);
      chk(array_req, {ad[i], pb(8'h5A), 1'b1});
      wait_idle();
    end
  endtask
  task automatic t_modes;
    proc.wr(4'h9, 8'h23, 1'b1);
    wait_idle();
    chk({23'h000000, dur > 45}, 24'h000000);
    rdchk(4'h8, pb(8'hFF));
    proc.wr(4'h9, 8'h41, 1'b1);
    chk(array_req, {14'h1A5A, 9'h000, 1'b1});
    wait_idle();
    rdchk(4'h8, 9'h000);
  endtask
  task automatic end_of_test;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 5000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    fails = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_read();
    t_auto();
    t_modes();
    end_of_test();
  end
endmodule // core_memory_register_interface_test
